// ===== rtl/bstap_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module bstap_fifo
#(
  parameter WIDTH = 1,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clk,
  input wire reset,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] count;
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;

  // Honest flags from the fill count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @*
  begin
    out_data = mem[rd_ptr];
  end

  // Pointers wrap at the depth so any depth that fits in AW pointer bits works
  always @(posedge clk)
  begin
    if (reset || flush)
    begin
      count <= {(AW+1){1'b0}};
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
          : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
          : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // bstap_fifo

// ===== rtl/bstap_map.vh
// Constants for the boundary-scan test access port
`ifndef BSTAP_MAP_VH
`define BSTAP_MAP_VH
// Controller states, binary coded
`define BSTAP_ST_RESET 4'h0
`define BSTAP_ST_IDLE 4'h1
`define BSTAP_ST_SEL_DR 4'h2
`define BSTAP_ST_CAP_DR 4'h3
`define BSTAP_ST_SH_DR 4'h4
`define BSTAP_ST_EX1_DR 4'h5
`define BSTAP_ST_PA_DR 4'h6
`define BSTAP_ST_EX2_DR 4'h7
`define BSTAP_ST_UP_DR 4'h8
`define BSTAP_ST_SEL_IR 4'h9
`define BSTAP_ST_CAP_IR 4'hA
`define BSTAP_ST_SH_IR 4'hB
`define BSTAP_ST_EX1_IR 4'hC
`define BSTAP_ST_PA_IR 4'hD
`define BSTAP_ST_EX2_IR 4'hE
`define BSTAP_ST_UP_IR 4'hF
// Instruction codes
`define BSTAP_IR_WIDTH 3
`define BSTAP_INS_EXTEST 3'h0
`define BSTAP_INS_IDCODE 3'h1
`define BSTAP_INS_SAMPZ 3'h2
`define BSTAP_INS_SAMPLE 3'h4
`define BSTAP_INS_BYPASS 3'h7
`define BSTAP_IR_RESET 3'h1
// Data register sizes and fixed captures
`define BSTAP_ID_WIDTH 32
`define BSTAP_BSR_WIDTH 129
`define BSTAP_ID_START_BIT 0
`define BSTAP_BYPASS_CAPTURE 1'h0
`define BSTAP_INTERNAL_CAPTURE 1'h1
`define BSTAP_TMS_RESET_EDGES 5
`endif

// ===== rtl/bstap_sync.v
// Two-flop synchroniser for the test pins
`timescale 1ns/100ps
module bstap_sync
#(
  parameter WIDTH = 3
)
(
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk)
  begin
    if (reset)
    begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // bstap_sync

// ===== rtl/bstap_top.v
// Boundary-scan test access port: controller, instruction and data regs
`timescale 1ns/100ps
`include "bstap_map.vh"
module bstap_top
#(
  parameter BSR_WIDTH = `BSTAP_BSR_WIDTH,
  parameter OUT_CELLS = 40,
  parameter FIFO_DEPTH = 16,
  parameter [19:0] ID_UPPER = 20'h0ABCD, // Arbitrary part field
  parameter [10:0] ID_MAKER = 11'h2A5 // Arbitrary maker field
)
(
  input wire clk,
  input wire reset,
  input wire test_clock,
  input wire test_mode_select,
  input wire test_data_in,
  output reg test_data_out,
  output reg test_data_out_oe,
  input wire [BSR_WIDTH-2:0] ring_state,
  input wire [OUT_CELLS-1:0] func_outputs,
  input wire func_read_drive_en,
  output reg [OUT_CELLS-1:0] pin_outputs,
  output reg read_drive_en,
  output reg on_die_termination_en,
  output reg [`BSTAP_IR_WIDTH-1:0] active_instruction,
  output reg [3:0] tap_state
);
  localparam IDW = `BSTAP_ID_WIDTH;
  localparam [IDW-1:0] ID_CODE = {ID_UPPER, ID_MAKER, 1'b1};

  wire [2:0] pins_sync;
  reg tck_prev;
  wire tck_rise;
  wire tck_fall;
  wire tms_s;
  wire tdi_s;
  reg [3:0] next_tap_state;
  reg [`BSTAP_IR_WIDTH-1:0] instruction_register;
  reg [`BSTAP_IR_WIDTH-1:0] next_active;
  reg shortest_path_bit;
  reg [IDW-1:0] id_shift;
  reg [BSR_WIDTH-1:0] bsr_shift;
  reg [BSR_WIDTH-1:0] bsr_update;
  reg serial_bit;
  reg [2:0] tms_high_count;
  reg fall_d;
  wire tms_reset_hit;
  wire in_shift;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_data;
  wire is_extest;
  wire is_sampz;
  wire bsr_selected;

  // Decode of an instruction, used for the active code only
  function bsr_instr;
    input [`BSTAP_IR_WIDTH-1:0] code;
    begin
      bsr_instr = (code == `BSTAP_INS_EXTEST) ||
        (code == `BSTAP_INS_SAMPZ) || (code == `BSTAP_INS_SAMPLE);
    end
  endfunction

  // Pins arrive from another domain, so pass two flops first
  bstap_sync
  #(
    .WIDTH(3)
  )
  u_sync
  (
    .clk(clk),
    .reset(reset),
    .async_in({test_clock, test_mode_select, test_data_in}),
    .sync_out(pins_sync)
  );

  assign tms_s = pins_sync[1];
  assign tdi_s = pins_sync[0];
  assign tck_rise = pins_sync[2] && !tck_prev;
  assign tck_fall = !pins_sync[2] && tck_prev;

  // Edge finder on the synchronised test clock; fall_d marks the clk
  // after a fall, when the queued serial bit is ready to leave
  always @(posedge clk)
  begin
    if (reset)
    begin
      tck_prev <= 1'b0;
      fall_d <= 1'b0;
    end
    else
    begin
      tck_prev <= pins_sync[2];
      fall_d <= tck_fall;
    end
  end

  always @*
  begin
    case (tap_state)
      `BSTAP_ST_RESET: next_tap_state = tms_s ? `BSTAP_ST_RESET
        : `BSTAP_ST_IDLE;
      `BSTAP_ST_IDLE: next_tap_state = tms_s ? `BSTAP_ST_SEL_DR
        : `BSTAP_ST_IDLE;
      `BSTAP_ST_SEL_DR: next_tap_state = tms_s ? `BSTAP_ST_SEL_IR
        : `BSTAP_ST_CAP_DR;
      `BSTAP_ST_CAP_DR: next_tap_state = tms_s ? `BSTAP_ST_EX1_DR
        : `BSTAP_ST_SH_DR;
      `BSTAP_ST_SH_DR: next_tap_state = tms_s ? `BSTAP_ST_EX1_DR
        : `BSTAP_ST_SH_DR;
      `BSTAP_ST_EX1_DR: next_tap_state = tms_s ? `BSTAP_ST_UP_DR
        : `BSTAP_ST_PA_DR;
      `BSTAP_ST_PA_DR: next_tap_state = tms_s ? `BSTAP_ST_EX2_DR
        : `BSTAP_ST_PA_DR;
      `BSTAP_ST_EX2_DR: next_tap_state = tms_s ? `BSTAP_ST_UP_DR
        : `BSTAP_ST_SH_DR;
      `BSTAP_ST_UP_DR: next_tap_state = tms_s ? `BSTAP_ST_SEL_DR
        : `BSTAP_ST_IDLE;
      `BSTAP_ST_SEL_IR: next_tap_state = tms_s ? `BSTAP_ST_RESET
        : `BSTAP_ST_CAP_IR;
      `BSTAP_ST_CAP_IR: next_tap_state = tms_s ? `BSTAP_ST_EX1_IR
        : `BSTAP_ST_SH_IR;
      `BSTAP_ST_SH_IR: next_tap_state = tms_s ? `BSTAP_ST_EX1_IR
        : `BSTAP_ST_SH_IR;
      `BSTAP_ST_EX1_IR: next_tap_state = tms_s ? `BSTAP_ST_UP_IR
        : `BSTAP_ST_PA_IR;
      `BSTAP_ST_PA_IR: next_tap_state = tms_s ? `BSTAP_ST_EX2_IR
        : `BSTAP_ST_PA_IR;
      `BSTAP_ST_EX2_IR: next_tap_state = tms_s ? `BSTAP_ST_UP_IR
        : `BSTAP_ST_SH_IR;
      `BSTAP_ST_UP_IR: next_tap_state = tms_s ? `BSTAP_ST_SEL_DR
        : `BSTAP_ST_IDLE;
      default: next_tap_state = `BSTAP_ST_RESET;
    endcase
  end

  // step on each test clock rise
  always @(posedge clk)
  begin
    if (reset)
      tap_state <= `BSTAP_ST_RESET;
    else if (tck_rise)
      tap_state <= tms_reset_hit ? `BSTAP_ST_RESET : next_tap_state;
  end

  // count mode-select-high edges
  // The graph already reaches reset in five edges; this counter is a
  // safety net that forces reset even from a corrupted state code.
  always @(posedge clk)
  begin
    if (reset)
      tms_high_count <= 3'h0;
    else if (tck_rise)
    begin
      if (!tms_s)
        tms_high_count <= 3'h0;
      else if (tms_high_count != 3'h7)
        tms_high_count <= tms_high_count + 3'h1;
    end
  end

  // Fifth consecutive high rise; a low on this rise must not count
  assign tms_reset_hit = tms_s &&
    (tms_high_count >= `BSTAP_TMS_RESET_EDGES - 1);

  assign in_shift = (tap_state == `BSTAP_ST_SH_IR) ||
    (tap_state == `BSTAP_ST_SH_DR);

  // data in sampled only while shifting
  always @(posedge clk)
  begin
    if (reset)
    begin
      instruction_register <= `BSTAP_IR_RESET;
      active_instruction <= `BSTAP_IR_RESET;
    end
    else if (tck_rise)
    begin
      if (tap_state == `BSTAP_ST_RESET || tms_reset_hit)
      begin
        instruction_register <= `BSTAP_IR_RESET;
        active_instruction <= `BSTAP_IR_RESET;
      end
      else if (tap_state == `BSTAP_ST_CAP_IR)
        instruction_register <= `BSTAP_IR_RESET;
      else if (tap_state == `BSTAP_ST_SH_IR)
        instruction_register <= {tdi_s, instruction_register[2:1]};
      else if (tap_state == `BSTAP_ST_UP_IR)
        active_instruction <= next_active;
    end
  end

  // reserved codes fall back to bypass so no hidden mode runs
  always @*
  begin
    case (instruction_register)
      `BSTAP_INS_EXTEST,
      `BSTAP_INS_IDCODE,
      `BSTAP_INS_SAMPZ,
      `BSTAP_INS_SAMPLE: next_active = instruction_register;
      default: next_active = `BSTAP_INS_BYPASS;
    endcase
  end

  assign is_extest = (active_instruction == `BSTAP_INS_EXTEST);
  assign is_sampz = (active_instruction == `BSTAP_INS_SAMPZ);
  assign bsr_selected = bsr_instr(active_instruction);

  always @(posedge clk)
  begin
    if (reset)
    begin
      shortest_path_bit <= `BSTAP_BYPASS_CAPTURE;
      id_shift <= ID_CODE;
      bsr_shift <= {BSR_WIDTH{1'b0}};
    end
    else if (tck_rise)
    begin
      if (tap_state == `BSTAP_ST_CAP_DR)
      begin
        shortest_path_bit <= `BSTAP_BYPASS_CAPTURE;
        if (active_instruction == `BSTAP_INS_IDCODE)
          id_shift <= ID_CODE;
        if (bsr_selected)
          bsr_shift <= {`BSTAP_INTERNAL_CAPTURE, ring_state};
      end
      else if (tap_state == `BSTAP_ST_SH_DR)
      begin
        if (active_instruction == `BSTAP_INS_IDCODE)
          id_shift <= {tdi_s, id_shift[IDW-1:1]};
        else if (bsr_selected)
          bsr_shift <= {tdi_s, bsr_shift[BSR_WIDTH-1:1]};
        else
          shortest_path_bit <= tdi_s;
      end
    end
  end

  // boundary values reach pins only at Update-DR
  always @(posedge clk)
  begin
    if (reset)
      bsr_update <= {BSR_WIDTH{1'b0}};
    else if (tck_rise && tap_state == `BSTAP_ST_UP_DR && bsr_selected)
      bsr_update <= bsr_shift;
  end

  // Serial source for the current shift path
  always @*
  begin
    if (tap_state == `BSTAP_ST_SH_IR)
      serial_bit = instruction_register[0];
    else if (active_instruction == `BSTAP_INS_IDCODE)
      serial_bit = id_shift[0];
    else if (bsr_selected)
      serial_bit = bsr_shift[0];
    else
      serial_bit = shortest_path_bit;
  end

  // Each fall in a shift state queues the current low bit of the path,
  // which leaves one clk later together with the driver enable, so the
  // first captured bit is on the pin before the first shift rise.
  bstap_fifo
  #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  )
  u_out_fifo
  (
    .clk(clk),
    .reset(reset),
    .flush(!in_shift && tck_fall),
    .in_data(serial_bit),
    .in_valid(tck_fall && in_shift),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fall_d)
  );

  // output presented on the falling edge
  always @(posedge clk)
  begin
    if (reset)
    begin
      test_data_out <= 1'b0;
      test_data_out_oe <= 1'b0;
    end
    else if (fall_d)
    begin
      test_data_out_oe <= in_shift;
      if (fifo_out_valid)
        test_data_out <= fifo_out_data;
    end
  end

  // functional path passes untouched outside extest/sample-z
  // termination off in extest and sample-z
  always @(posedge clk)
  begin
    if (reset)
    begin
      pin_outputs <= {OUT_CELLS{1'b0}};
      read_drive_en <= 1'b0;
      on_die_termination_en <= 1'b1;
    end
    else
    begin
      on_die_termination_en <= !(is_extest || is_sampz);
      if (is_extest)
      begin
        pin_outputs <= bsr_update[OUT_CELLS-1:0];
        read_drive_en <= bsr_update[BSR_WIDTH-1];
      end
      else
      begin
        pin_outputs <= func_outputs;
        read_drive_en <= is_sampz ? 1'b0 : func_read_drive_en;
      end
    end
  end
endmodule // bstap_top

// ===== testbench/bstap_host.sv
// Model of the external test controller driving the serial port
`timescale 1ns/100ps
module bstap_host
(
  input wire clk,
  output logic test_clock,
  output logic test_mode_select,
  output logic test_data_in,
  input wire test_data_out
);
  // Test clock rests low between steps
  initial
  begin
    test_clock = 1'b0;
    test_mode_select = 1'b1;
    test_data_in = 1'b0;
  end
  // One 80 ns test clock period. Outside shifts the data line toggles,
  // so a device that samples it wrongly cannot go unnoticed.
  // output read late in low phase
  task step(input logic tms, input logic sh, input logic tdi,
            output logic tdo);
    test_mode_select = tms;
    test_data_in = sh ? tdi : ~test_data_in;
    repeat (10) @(posedge clk);
    #1;
    tdo = test_data_out;
    test_clock = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    test_clock = 1'b0;
  endtask
endmodule // bstap_host

// ===== testbench/bstap_top_asserts.sv
// Concurrent checks on the test access port, bound to its top module
`timescale 1ns/100ps
`include "bstap_map.vh"
module bstap_checker
(
  input wire clk,
  input wire reset,
  input wire test_clock,
  input wire test_data_out,
  input wire test_data_out_oe,
  input wire read_drive_en,
  input wire on_die_termination_en,
  input wire [2:0] active_instruction,
  input wire [3:0] tap_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Data scan starting to drive its first bit
  sequence s_dr_go;
    $rose(test_data_out_oe) && tap_state == `BSTAP_ST_SH_DR;
  endsequence
  property p_rst_val;
    $fell(reset) |-> tap_state == `BSTAP_ST_RESET &&
      active_instruction == `BSTAP_IR_RESET;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("state after reset wrong");
  // Pin sync delay puts steps a few clk into the high phase
  property p_step;
    $changed(tap_state) |-> test_clock && !$past(test_clock, 8);
  endproperty
  a_step: assert property (p_step)
    else $error("state moved off a rising edge");
  property p_tdo_fall;
    $changed(test_data_out) |-> !test_clock && $past(test_clock, 8);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("serial out moved off a falling edge");
  property p_oe_on;
    $rose(test_data_out_oe) |->
      tap_state inside {`BSTAP_ST_SH_IR, `BSTAP_ST_SH_DR};
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("driver on outside shift");
  property p_id_lsb;
    s_dr_go ##0 (active_instruction == `BSTAP_INS_IDCODE) |-> test_data_out;
  endproperty
  a_id_lsb: assert property (p_id_lsb)
    else $error("id start bit not first");
  property p_ir_load;
    $changed(active_instruction) |->
      tap_state inside {`BSTAP_ST_UP_IR, `BSTAP_ST_RESET} ||
      $past(tap_state) inside {`BSTAP_ST_UP_IR, `BSTAP_ST_RESET};
  endproperty
  a_ir_load: assert property (p_ir_load)
    else $error("instruction changed early");
  property p_odt;
    active_instruction == $past(active_instruction) |->
      on_die_termination_en == !(active_instruction inside
      {`BSTAP_INS_EXTEST, `BSTAP_INS_SAMPZ});
  endproperty
  a_odt: assert property (p_odt)
    else $error("termination enable wrong");
  property p_hiz;
    (active_instruction == `BSTAP_INS_SAMPZ) [*2] |-> !read_drive_en;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("read drivers on in sample-z");
endmodule // bstap_checker
bind bstap_top bstap_checker bstap_checker_i
(
  .clk(clk), .reset(reset), .test_clock(test_clock),
  .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe),
  .read_drive_en(read_drive_en),
  .on_die_termination_en(on_die_termination_en),
  .active_instruction(active_instruction), .tap_state(tap_state)
);

// ===== testbench/tb_boundary_scan_tap.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
`include "bstap_map.vh"
module tb_boundary_scan_tap;
  localparam logic [19:0] ID_UPPER = 20'h13579; // Arbitrary value
  localparam logic [10:0] ID_MAKER = 11'h0C3; // Arbitrary value
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic func_read_drive_en = 1'b1;
  logic [127:0] ring_state = 128'h0123456789ABCDEFFEDCBA9876543210;
  logic [39:0] func_outputs = 40'hA55A0FF0C3;
  logic [128:0] d1 = {1'b0, 88'h0, 40'hC33C55AA01};
  logic [128:0] d2 = {1'b1, 88'h0, 40'h3CC3AA55FE};
  wire test_clock, test_mode_select, test_data_in, test_data_out;
  wire test_data_out_oe, read_drive_en, on_die_termination_en;
  wire [39:0] pin_outputs;
  wire [2:0] active_instruction;
  wire [3:0] tap_state;
  int err_count = 0;
  int n_tests = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  bstap_top #(.ID_UPPER(ID_UPPER), .ID_MAKER(ID_MAKER)) bstap_top_i
  (
    .clk(clk), .reset(reset), .test_clock(test_clock),
    .test_mode_select(test_mode_select), .test_data_in(test_data_in),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe),
    .ring_state(ring_state), .func_outputs(func_outputs),
    .func_read_drive_en(func_read_drive_en), .pin_outputs(pin_outputs),
    .read_drive_en(read_drive_en),
    .on_die_termination_en(on_die_termination_en),
    .active_instruction(active_instruction), .tap_state(tap_state)
  );
  bstap_host bstap_host_i
  (
    .clk(clk), .test_clock(test_clock),
    .test_mode_select(test_mode_select), .test_data_in(test_data_in),
    .test_data_out(test_data_out)
  );
  task chk(input logic [128:0] got, input logic [128:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task st(input logic tms);
    logic q;
    bstap_host_i.step(tms, 1'b0, 1'b0, q);
  endtask
  // From Idle into a shift state, n bits LSB first, ending in Exit1
  task scan(input logic ir, input int n, input logic [128:0] d,
            output logic [128:0] q);
    logic b;
    q = '0;
    st(1'b1);
    if (ir)
      st(1'b1);
    st(1'b0);
    st(1'b0);
    // Let the first fall in shift land before looking at the driver
    repeat (8) @(posedge clk);
    #1;
    chk(129'(test_data_out_oe), 129'h1);
    for (int i = 0; i < n; i++)
    begin
      bstap_host_i.step(i == n - 1, 1'b1, d[i], b);
      q[i] = b;
    end
  endtask
  // Exit1, then Update, then back to Idle
  task upd;
    st(1'b1);
    st(1'b0);
  endtask
  task load(input logic [2:0] code);
    logic [128:0] q;
    logic [2:0] was;
    was = active_instruction;
    scan(1'b1, 3, 129'(code), q);
    chk(q, 129'h1);
    chk(129'(active_instruction), 129'(was));
    upd();
    chk(129'(active_instruction), 129'(code));
    chk(129'(test_data_out_oe), 129'h0);
  endtask
  task t_reset;
    chk(129'(tap_state), 129'(`BSTAP_ST_RESET));
    chk(129'(active_instruction), 129'(`BSTAP_IR_RESET));
    st(1'b0);
    chk(129'(tap_state), 129'(`BSTAP_ST_IDLE));
  endtask
  task t_idcode;
    logic [128:0] q;
    load(`BSTAP_INS_IDCODE);
    scan(1'b0, 32, 129'h0, q);
    upd();
    chk(q, 129'({ID_UPPER, ID_MAKER, 1'b1}));
  endtask
  task t_bypass;
    logic [128:0] q;
    load(`BSTAP_INS_BYPASS);
    scan(1'b0, 4, 129'hD, q);
    upd();
    chk(q, 129'hA);
    chk(129'(on_die_termination_en), 129'h1);
  endtask
  task t_sample;
    logic [128:0] q;
    load(`BSTAP_INS_SAMPLE);
    scan(1'b0, 129, d1, q);
    upd();
    chk(q, {1'b1, ring_state});
    chk(129'(pin_outputs), 129'(func_outputs));
    chk(129'(read_drive_en), 129'h1);
  endtask
  task t_sampz;
    logic [128:0] q;
    load(`BSTAP_INS_SAMPZ);
    chk(129'(on_die_termination_en), 129'h0);
    chk(129'(read_drive_en), 129'h0);
    scan(1'b0, 129, d2, q);
    upd();
    chk(q, {1'b1, ring_state});
  endtask
  // Pins follow the cells only at Update-DR, internal cell gates drivers
  task t_extest;
    logic [128:0] q;
    load(`BSTAP_INS_EXTEST);
    chk(129'(on_die_termination_en), 129'h0);
    scan(1'b0, 129, d1, q);
    chk(q, {1'b1, ring_state});
    upd();
    chk(129'(pin_outputs), 129'(d1[39:0]));
    chk(129'(read_drive_en), 129'h0);
    scan(1'b0, 129, d2, q);
    chk(129'(pin_outputs), 129'(d1[39:0]));
    upd();
    chk(129'(pin_outputs), 129'(d2[39:0]));
    chk(129'(read_drive_en), 129'h1);
  endtask
  // Mode select held high from inside a data shift
  task t_tms_reset;
    st(1'b1);
    st(1'b0);
    st(1'b0);
    // Four highs then a low must leave the instruction alone
    repeat (4) st(1'b1);
    st(1'b0);
    chk(129'(tap_state), 129'(`BSTAP_ST_CAP_IR));
    chk(129'(active_instruction), 129'(`BSTAP_INS_EXTEST));
    st(1'b1);
    upd();
    load(`BSTAP_INS_EXTEST);
    st(1'b1);
    st(1'b0);
    st(1'b0);
    repeat (5) st(1'b1);
    chk(129'(tap_state), 129'(`BSTAP_ST_RESET));
    chk(129'(active_instruction), 129'(`BSTAP_IR_RESET));
    chk(129'(on_die_termination_en), 129'h1);
  endtask
  task results;
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence; only public codes are loaded
  initial
  begin
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    t_reset();
    t_idcode();
    t_bypass();
    t_sample();
    t_sampz();
    t_extest();
    t_tms_reset();
    results();
  end
  // Watchdog, about twice the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("ERROR %0t: timeout", $time);
    results();
  end
endmodule // tb_boundary_scan_tap
